// [rtl/gp2pc_pkg.sv]
package gp2pc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [15:0] CTRL_ADDR = 16'h4039;
  localparam logic [15:0] LEVEL_ADDR = 16'h40f0;
  localparam logic [15:0] CTRL_RESET = 16'ha400;
  localparam logic [15:0] CTRL_WMASK = 16'hfe8f;
  localparam logic [15:0] LEVEL_RESET = 16'h0000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DIR_BIT = 15;
  localparam int PULL_LSB = 13;
  localparam int IRQ_MODE_BIT = 12;
  localparam int SUPPLY_BIT = 11;
  localparam int POL_BIT = 10;
  localparam int OD_BIT = 9;
  localparam int ENA_BIT = 7;
  localparam int FN_LSB = 0;
  localparam int LEVEL_OUT_BIT = 0;
  localparam int LEVEL_IN_BIT = 1;

  // ****************************************************************
  // field encodings
  // ****************************************************************
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int LONG_DEBOUNCE_NS = 1000000;
  localparam int LONG_DEBOUNCE_CYC =
    (LONG_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic pin_direction;
    logic [1:0] pin_resistor_select;
    logic irq_edge_mode;
    logic io_supply_select;
    logic pin_polarity;
    logic open_drain_select;
    logic rsv8;
    logic pin_enable;
    logic [2:0] rsv6_4;
    logic [3:0] pin_function_code;
  } gp2pc_ctrl_t;

  typedef struct packed {
    logic gpio_level;
    logic pwr_onoff_req;
    logic sleep_wake_req;
    logic sleep_req;
    logic pwr_on_req;
    logic watchdog_rst;
    logic voltage_scale_select_one;
    logic voltage_scale_select_two;
    logic hw_enable_one;
    logic hw_enable_two;
    logic hw_control_one;
    logic hw_control_two;
  } gp2pc_in_role_t;

  typedef struct packed {
    logic osc_32k;
    logic on_state;
    logic sleep_state;
    logic state_change;
    logic dvs_done_one;
    logic dvs_done_two;
    logic ext_pwr_en_one;
    logic ext_pwr_en_two;
    logic system_supply_good;
    logic converter_power_good;
    logic ext_pwr_clk;
    logic aux_reset;
  } gp2pc_out_src_t;

endpackage

// [rtl/gp2pc_top.sv]
`timescale 1ns/1ps
module gp2pc_top #(
  parameter int DEBOUNCE_CYCLES = gp2pc_pkg::LONG_DEBOUNCE_CYC,
  parameter int CNT_W = 20
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  // pin
  input wire logic PIN_IN_I,
  output logic PIN_OUT_O,
  output logic PIN_OE_O,
  output logic PULL_UP_EN_O,
  output logic PULL_DOWN_EN_O,
  output logic IO_SUPPLY_SEL_O,
  // input roles towards internal units
  output gp2pc_pkg::gp2pc_in_role_t IN_ROLE_O,
  output logic PIN_EDGE_O,
  // output role sources from internal units
  input wire gp2pc_pkg::gp2pc_out_src_t OUT_SRC_I
);
  import gp2pc_pkg::*;

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (DEBOUNCE_CYCLES < 1 || CNT_W < 1 || CNT_W > 30 ||
      DEBOUNCE_CYCLES > (1 << CNT_W) - 1) begin : g_param_check
    $error("gp2pc_top: debounce count does not fit its counter");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic apply_pol(input logic lvl, input logic pol);
    apply_pol = pol ? lvl : ~lvl;
  endfunction

  localparam logic [CNT_W-1:0] DB_LAST =
    CNT_W'(DEBOUNCE_CYCLES - 1);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic level_out_reg;
  logic [15:0] rdata_reg;
  gp2pc_ctrl_t ctrl;
  logic ctrl_sel;
  logic level_sel;

  assign ctrl = gp2pc_ctrl_t'(ctrl_reg);
  assign ctrl_sel = (REG_ADDR_I == CTRL_ADDR);
  assign level_sel = (REG_ADDR_I == LEVEL_ADDR);
  assign ctrl_next = REG_WDATA_I & CTRL_WMASK;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_reg <= CTRL_RESET;
    end else if (REG_WR_I && ctrl_sel) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      level_out_reg <= LEVEL_RESET[LEVEL_OUT_BIT];
    end else if (REG_WR_I && level_sel) begin
      level_out_reg <= REG_WDATA_I[LEVEL_OUT_BIT];
    end
  end

  // ****************************************************************
  // pin input path
  // ****************************************************************
  logic sync1_reg;
  logic sync2_reg;
  logic stable_reg;
  logic [CNT_W-1:0] db_cnt_reg;
  logic prev_reg;
  logic long_db;
  logic phys_in;
  logic logic_in;
  logic input_mode;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= PIN_IN_I;
      sync2_reg <= sync1_reg;
    end
  end

  // long debounce: level must hold for the full count
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      stable_reg <= 1'b0;
      db_cnt_reg <= '0;
    end else if (sync2_reg == stable_reg) begin
      db_cnt_reg <= '0;
    end else if (db_cnt_reg == DB_LAST) begin
      stable_reg <= sync2_reg;
      db_cnt_reg <= '0;
    end else begin
      db_cnt_reg <= db_cnt_reg + CNT_W'(1);
    end
  end

  always_comb begin
    case (ctrl.pin_function_code)
      4'h0: long_db = 1'b1;
      4'h4: long_db = 1'b1;
      4'he: long_db = 1'b1;
      4'hf: long_db = 1'b1;
      default: long_db = 1'b0;
    endcase
  end

  assign input_mode = ctrl.pin_direction & ctrl.pin_enable;
  assign phys_in = long_db ? stable_reg : sync2_reg;
  assign logic_in = apply_pol(phys_in, ctrl.pin_polarity);

  // ****************************************************************
  // input role routing
  // ****************************************************************
  gp2pc_in_role_t role_next;
  gp2pc_in_role_t role_reg;

  always_comb begin
    role_next = '0;
    if (input_mode) begin
      case (ctrl.pin_function_code)
        4'h0: role_next.gpio_level = logic_in;
        4'h1: role_next.gpio_level = logic_in;
        4'h2: role_next.pwr_onoff_req = logic_in;
        4'h3: role_next.sleep_wake_req = logic_in;
        4'h4: role_next.sleep_wake_req = logic_in;
        4'h5: role_next.sleep_req = logic_in;
        4'h6: role_next.pwr_on_req = logic_in;
        4'h7: role_next.watchdog_rst = logic_in;
        4'h8: role_next.voltage_scale_select_one = logic_in;
        4'h9: role_next.voltage_scale_select_two = logic_in;
        4'ha: role_next.hw_enable_one = logic_in;
        4'hb: role_next.hw_enable_two = logic_in;
        4'hc: role_next.hw_control_one = logic_in;
        4'hd: role_next.hw_control_two = logic_in;
        4'he: role_next.hw_control_one = logic_in;
        4'hf: role_next.hw_control_two = logic_in;
        default: role_next = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      role_reg <= '0;
    end else begin
      role_reg <= role_next;
    end
  end

  // ****************************************************************
  // edge event
  // ****************************************************************
  logic edge_next;
  logic edge_reg;

  always_comb begin
    if (ctrl.irq_edge_mode) begin
      edge_next = logic_in ^ prev_reg;
    end else begin
      // logical rise is a physical fall when inverted
      edge_next = logic_in & ~prev_reg;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      prev_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      prev_reg <= logic_in;
      edge_reg <= edge_next & input_mode;
    end
  end

  // ****************************************************************
  // pin output path
  // ****************************************************************
  logic drv_logic;
  logic drv_phys;
  logic drive_mode;
  logic out_reg;
  logic oe_reg;

  always_comb begin
    case (ctrl.pin_function_code)
      4'h0: drv_logic = level_out_reg;
      4'h1: drv_logic = OUT_SRC_I.osc_32k;
      4'h2: drv_logic = OUT_SRC_I.on_state;
      4'h3: drv_logic = OUT_SRC_I.sleep_state;
      4'h4: drv_logic = OUT_SRC_I.state_change;
      4'h8: drv_logic = OUT_SRC_I.dvs_done_one;
      4'h9: drv_logic = OUT_SRC_I.dvs_done_two;
      4'ha: drv_logic = OUT_SRC_I.ext_pwr_en_one;
      4'hb: drv_logic = OUT_SRC_I.ext_pwr_en_two;
      4'hc: drv_logic = OUT_SRC_I.system_supply_good;
      4'hd: drv_logic = OUT_SRC_I.converter_power_good;
      4'he: drv_logic = OUT_SRC_I.ext_pwr_clk;
      4'hf: drv_logic = OUT_SRC_I.aux_reset;
      default: drv_logic = 1'b0;
    endcase
  end

  assign drive_mode = ~ctrl.pin_direction & ctrl.pin_enable;
  assign drv_phys = apply_pol(drv_logic, ctrl.pin_polarity);

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (!drive_mode) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (ctrl.open_drain_select) begin
      out_reg <= 1'b0;
      oe_reg <= ~drv_phys;
    end else begin
      out_reg <= drv_phys;
      oe_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // pad controls
  // ****************************************************************
  logic pu_reg;
  logic pd_reg;
  logic sup_reg;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pu_reg <= 1'b0;
      pd_reg <= 1'b0;
      sup_reg <= 1'b0;
    end else begin
      pu_reg <= (ctrl.pin_resistor_select == PULL_UP);
      pd_reg <= (ctrl.pin_resistor_select == PULL_DOWN);
      sup_reg <= ctrl.io_supply_select;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= '0;
    end else if (REG_RD_I && ctrl_sel) begin
      rdata_reg <= ctrl_reg & CTRL_WMASK;
    end else if (REG_RD_I && level_sel) begin
      rdata_reg <= '0;
      rdata_reg[LEVEL_OUT_BIT] <= level_out_reg;
      rdata_reg[LEVEL_IN_BIT] <= logic_in;
    end else begin
      rdata_reg <= '0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign REG_RDATA_O = rdata_reg;
  assign PIN_OUT_O = out_reg;
  assign PIN_OE_O = oe_reg;
  assign PULL_UP_EN_O = pu_reg;
  assign PULL_DOWN_EN_O = pd_reg;
  assign IO_SUPPLY_SEL_O = sup_reg;
  assign IN_ROLE_O = role_reg;
  assign PIN_EDGE_O = edge_reg;

endmodule // gp2pc_top

// [test/gp2pc_assertions.sv]
`timescale 1ns/1ps
module gp2pc_assertions (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  // pad
  input wire logic PIN_OUT_O,
  input wire logic PIN_OE_O,
  input wire logic PULL_UP_EN_O,
  input wire logic PULL_DOWN_EN_O,
  input wire logic IO_SUPPLY_SEL_O,
  // roles
  input wire gp2pc_pkg::gp2pc_in_role_t IN_ROLE_O,
  input wire logic PIN_EDGE_O
);
  import gp2pc_pkg::*;
  // ****
  // properties
  // ****
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire cw = REG_WR_I && REG_ADDR_I == CTRL_ADDR;
  property p_pads;
    cw |-> ##2 (IO_SUPPLY_SEL_O == $past(REG_WDATA_I[11], 2)
      && PULL_UP_EN_O == ($past(REG_WDATA_I[14:13], 2) == 2'h2)
      && PULL_DOWN_EN_O == ($past(REG_WDATA_I[14:13], 2) == 2'h1));
  endproperty
  property p_tri;
    cw && !REG_WDATA_I[7] |-> ##2 (!PIN_OE_O && IN_ROLE_O == '0);
  endproperty
  property p_dir;
    cw && REG_WDATA_I[15] |-> ##2 !PIN_OE_O;
  endproperty
  property p_rd_idle;
    !REG_RD_I |=> REG_RDATA_O == 16'h0000;
  endproperty
  property p_rsv;
    REG_RD_I && REG_ADDR_I == CTRL_ADDR |=> (REG_RDATA_O & 16'h0170) == 0;
  endproperty
  property p_pull_excl;
    !(PULL_UP_EN_O && PULL_DOWN_EN_O);
  endproperty
  property p_out_oe;
    PIN_OUT_O |-> PIN_OE_O;
  endproperty
  property p_role_1hot;
    $onehot0(IN_ROLE_O);
  endproperty
  property p_edge_in;
    PIN_EDGE_O |-> !PIN_OE_O;
  endproperty
  a_pads: assert property (p_pads)
    else $error("pad config mismatch");
  a_tri: assert property (p_tri)
    else $error("disabled pin still active");
  a_dir: assert property (p_dir)
    else $error("input pin driven");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_rsv: assert property (p_rsv)
    else $error("unassigned bits not zero");
  a_pull_excl: assert property (p_pull_excl)
    else $error("both pulls on");
  a_out_oe: assert property (p_out_oe)
    else $error("output high while released");
  a_role_1hot: assert property (p_role_1hot)
    else $error("several roles active");
  a_edge_in: assert property (p_edge_in)
    else $error("edge event in output mode");
  c_edge: cover property (PIN_EDGE_O);
  c_drive: cover property (PIN_OE_O && PIN_OUT_O);
  c_role: cover property (IN_ROLE_O != '0);
endmodule // gp2pc_assertions

bind gp2pc_top gp2pc_assertions u_chk (.MCLK_I, .SYS_RST_I, .REG_ADDR_I,
  .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .PIN_OUT_O, .PIN_OE_O,
  .PULL_UP_EN_O, .PULL_DOWN_EN_O, .IO_SUPPLY_SEL_O, .IN_ROLE_O, .PIN_EDGE_O);

// [test/gp2pc_pin_model.sv]
`timescale 1ns/1ps
module gp2pc_pin_model (
  // clock
  input wire logic clk_i,
  // device pad
  input wire logic out_i,
  input wire logic oe_i,
  input wire logic pu_i,
  input wire logic pd_i,
  // external driver
  input wire logic drv_en_i,
  input wire logic drv_i,
  output logic pin_o
);
  logic last_reg = 1'b0;
  // ****
  // wire resolution
  // ****
  always_comb begin
    if (oe_i) pin_o = out_i;
    else if (drv_en_i) pin_o = drv_i;
    else if (pu_i) pin_o = 1'b1;
    else if (pd_i) pin_o = 1'b0;
    else pin_o = ~last_reg;
  end
  always_ff @(posedge clk_i) last_reg <= pin_o;
endmodule // gp2pc_pin_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import gp2pc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = '0, wdata = '0, rdata;
  logic wr = 1'b0, rd = 1'b0, drv_en = 1'b0, drv = 1'b0, pin;
  logic pout, poe, pu, pd, sup, edge_o;
  gp2pc_in_role_t role;
  gp2pc_out_src_t src = '0;
  int failures = 0, cmp_count = 0, ecnt = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (edge_o === 1'b1) ecnt++;
  gp2pc_top #(.DEBOUNCE_CYCLES(4)) DUT (.MCLK_I(mclk), .SYS_RST_I(rst),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .PIN_IN_I(pin), .PIN_OUT_O(pout), .PIN_OE_O(poe),
    .PULL_UP_EN_O(pu), .PULL_DOWN_EN_O(pd), .IO_SUPPLY_SEL_O(sup),
    .IN_ROLE_O(role), .PIN_EDGE_O(edge_o), .OUT_SRC_I(src));
  gp2pc_pin_model u_pin (.clk_i(mclk), .out_i(pout), .oe_i(poe), .pu_i(pu),
    .pd_i(pd), .drv_en_i(drv_en), .drv_i(drv), .pin_o(pin));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd16(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic setpin(input logic v);
    @(posedge mclk);
    drv <= v;
  endtask
  task end_of_test;
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [11:0] role_exp(input int c, input logic lv);
    int idx[16] = '{11, 11, 10, 9, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0, 1, 0};
    return lv ? 12'h001 << idx[c] : 12'h000;
  endfunction
  function automatic logic out_exp(input int c, input logic [11:0] s,
                                   input logic l);
    if (c == 0) return l;
    if (c >= 5 && c <= 7) return 1'b0;
    return c < 5 ? s[12 - c] : s[15 - c];
  endfunction
  // ****
  // sequence
  // ****
  initial begin
    #(25 * 20000);
    failures++;
    end_of_test;
  end
  initial begin
    logic [15:0] d, r;
    logic l, ph, lg;
    int c;
    void'($urandom(21));
    cyc(8);
    rst <= 1'b0;
    rd16(CTRL_ADDR, r);
    chk(r, 16'ha400, "ctrl reset");
    rd16(16'h4038, r);
    chk(r, 16'h0000, "unmapped read");
    wr16(16'h4038, 16'h0000);
    rd16(CTRL_ADDR, r);
    chk(r, CTRL_RESET, "unmapped write");
    repeat (20) begin
      d = 16'($urandom);
      if (d[14:13] == 2'h3) d[13] = 1'b0;
      wr16(CTRL_ADDR, d);
      rd16(CTRL_ADDR, r);
      chk(r, d & 16'hfe8f, "ctrl readback");
      r = 16'({d[14:13] == 2'h2, d[14:13] == 2'h1, d[11]});
      chk(16'({pu, pd, sup}), r, "pads");
    end
    @(posedge mclk);
    drv_en <= 1'b1;
    for (c = 0; c < 16; c++) begin
      wr16(CTRL_ADDR, 16'h8480 | 16'(c));
      cyc(12);
      ecnt = 0;
      setpin(1'b1);
      cyc(4);
      #1 lg = (c == 0 || c == 4 || c >= 14);
      chk(16'(role), 16'(role_exp(c, !lg)), "debounce");
      cyc(8);
      #1 chk(16'(role), 16'(role_exp(c, 1'b1)), "role");
      setpin(1'b0);
      cyc(12);
      #1 chk(16'({role, ecnt[3:0]}), 16'h0001, "rise only");
    end
    for (c = 0; c < 4; c++) begin
      wr16(CTRL_ADDR, 16'h8081 | 16'(c[0]) << 10 | 16'(c[1]) << 12);
      cyc(8);
      ecnt = 0;
      setpin(1'b1);
      cyc(8);
      #1 chk(16'(role), 16'(role_exp(1, c[0])), "polarity");
      chk(16'(ecnt), 16'(c[0] | c[1]), "rise event");
      rd16(LEVEL_ADDR, r);
      chk(r, 16'(c[0]) << 1, "input level read");
      ecnt = 0;
      setpin(1'b0);
      cyc(8);
      #1 chk(16'(ecnt), 16'(!c[0] | c[1]), "fall event");
    end
    @(posedge mclk);
    drv_en <= 1'b0;
    for (c = 0; c < 16; c++) begin
      d = 16'h4080 | 16'(c) | (16'($urandom) & 16'h0600);
      @(posedge mclk);
      src <= gp2pc_out_src_t'(12'($urandom));
      l = 1'($urandom);
      wr16(LEVEL_ADDR, 16'(l));
      wr16(CTRL_ADDR, d);
      cyc(3);
      #1 ph = out_exp(c, src, l) ^ !d[10];
      r = 16'({!d[9] | !ph, !d[9] & ph, ph});
      chk(16'({poe, pout, pin}), r, "drive");
    end
    wr16(CTRL_ADDR, 16'h4400);
    cyc(3);
    #1 chk(16'({poe, pout, role}), 16'h0000, "tristate");
    end_of_test;
  end
endmodule // testbench
